// ==== dv/ahb_host.sv ====
// Purpose: host model, single word AHB-Lite transfers
// Assumes: one slave, hready is its hreadyout
// Notes:   write data inverted when unused
`timescale 1ns/1ps
module ahb_host
(
  input  wire logic        clock,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  assign hsize = 3'h2;
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
  end
  // ---------------------------------------------------------------
  // one transfer
  // ---------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clock);
    while (hready !== 1'b1)
      @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? d : ~hwdata;
    @(posedge clock);
    while (hready !== 1'b1)
      @(posedge clock);
    q = hrdata;
  endtask
endmodule // ahb_host

// ==== dv/hwcfg_chk.sv ====
// Purpose: port assertions for the configuration block
// Assumes: hready tied to hreadyout
// Notes:   bound to the top module
`timescale 1ns/1ps
module hwcfg_chk
(
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        mgmtMdc,
  input wire logic        mgmtMdioOut,
  input wire logic        mgmtMdioOe_n,
  input wire logic        mgmtMdioIn,
  input wire logic        intMdc,
  input wire logic        intMdioOut,
  input wire logic        intMdioOe_n,
  input wire logic        intMdioIn,
  input wire logic        extMdc,
  input wire logic        extMdioOut,
  input wire logic        extMdioOe_n,
  input wire logic        extMdioIn,
  input wire logic [15:0] rxDataUsed,
  input wire logic        rxDataFull,
  input wire logic [15:0] txDataBytes,
  input wire logic [15:0] rxDataBytes,
  input wire logic [15:0] rxStatusBytes,
  input wire logic        macCsrReset,
  input wire logic        errorClear
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  data_phase_a: assert property (hsel && hready && htrans[1] && hreadyout |=> !hreadyout ##1 hreadyout)
    else $error("data phase not two cycles");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  side_parked_a: assert property ((extMdioOe_n && !extMdc && !extMdioOut) || (!intMdioOe_n && !intMdc && !intMdioOut))
    else $error("no management side parked");
  steer_int_a: assert property ($past(nrst) && extMdioOe_n && !$past(mgmtMdioOe_n) |-> intMdc == $past(mgmtMdc) && mgmtMdioIn == $past(intMdioIn))
    else $error("internal side not steered");
  steer_ext_a: assert property ($past(nrst) && !extMdioOe_n |-> extMdc == $past(mgmtMdc) && extMdioOut == $past(mgmtMdioOut) && mgmtMdioIn == $past(extMdioIn))
    else $error("external side not steered");
  pulse_len_a: assert property ($rose(macCsrReset) |-> macCsrReset[*8] ##1 !macCsrReset)
    else $error("soft reset pulse length wrong");
  err_clear_a: assert property (errorClear == macCsrReset)
    else $error("error clear not with reset");
  tx_size_a: assert property (txDataBytes != 16'h0 |-> txDataBytes[9:0] == 10'h200 && txDataBytes >= 16'h0600 && txDataBytes <= 16'h3600)
    else $error("tx data size wrong");
  rx_split_a: assert property (txDataBytes != 16'h0 |-> 17'(txDataBytes) + 17'(rxDataBytes) + 17'(rxStatusBytes) == 17'h03e00 && rxStatusBytes * 16'hf == rxDataBytes)
    else $error("rx split wrong");
  rx_full_a: assert property ($past(nrst, 2) && $stable(rxDataBytes) && $past(rxDataBytes, 2) == rxDataBytes |-> rxDataFull == (17'($past(rxDataUsed)) + 17'h10 >= 17'($past(rxDataBytes))))
    else $error("rx full flag wrong");
endmodule // hwcfg_chk

bind hw_config_fifo_partition hwcfg_chk u_chk (.clock, .nrst, .hsel, .htrans, .hready, .hreadyout, .hresp, .mgmtMdc,
  .mgmtMdioOut, .mgmtMdioOe_n, .mgmtMdioIn, .intMdc, .intMdioOut, .intMdioOe_n, .intMdioIn, .extMdc, .extMdioOut,
  .extMdioOe_n, .extMdioIn, .rxDataUsed, .rxDataFull, .txDataBytes, .rxDataBytes, .rxStatusBytes, .macCsrReset,
  .errorClear);

// ==== dv/tb_top.sv ====
// Purpose: self-checking bench for the configuration block
// Assumes: 200 MHz clock
// Notes:   random steering values from a fixed seed
`timescale 1ns/1ps
`include "hwcfg_params.svh"
module tb_top;
  logic        clock = 1'b0, nrst = 1'b0, mgmtMdc = 1'b0, mgmtMdioOut = 1'b0, mgmtMdioOe_n = 1'b1;
  logic        intMdioIn = 1'b0, extMdioIn = 1'b1, phyClkRunning = 1'b1, powerSaveExit = 1'b0;
  logic        txErrorEvt = 1'b0, rxErrorEvt = 1'b0, sel, en;
  logic        hsel, hwrite, hreadyout, hresp, mgmtMdioIn, intMdc, intMdioOut, intMdioOe_n, extMdc, extMdioOut;
  logic        extMdioOe_n, extMiiEnable, rxDataFull, regionFlush, macCsrReset, errorClear, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  sz;
  logic [15:0] rxDataUsed = 16'h0, txDataBytes, rxDataBytes, rxStatusBytes;
  logic [31:0] haddr, hwdata, hrdata, q;
  int          nMismatch = 0, samplesChecked = 0, nFlush = 0;
  always #2.5 clock = ~clock;
  // counts repartition pulses seen on the flush output
  always @(posedge clock)
    if (regionFlush === 1'b1)
      nFlush <= nFlush + 1;
  hw_config_fifo_partition u_dut (.clock, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .mgmtMdc, .mgmtMdioOut, .mgmtMdioOe_n, .mgmtMdioIn, .intMdc, .intMdioOut,
    .intMdioOe_n, .intMdioIn, .extMdc, .extMdioOut, .extMdioOe_n, .extMdioIn, .extMiiEnable, .phyClkRunning,
    .powerSaveExit, .txErrorEvt, .rxErrorEvt, .rxDataUsed, .rxDataFull, .txDataBytes, .rxDataBytes, .rxStatusBytes,
    .regionFlush, .macCsrReset, .errorClear, .irq);
  ahb_host u_host (.clock, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a);
    u_host.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic pollReset();
    q = 32'h1;
    for (int i = 0; i < 1000 && q[0] !== 1'b0; i++)
      rd(`HWCFG_OFF);
  endtask
  function automatic logic [31:0] txExp(input logic [3:0] s);
    return {16'h0, 16'(s) * 16'h0400 - 16'h0200};
  endfunction
  function automatic logic [31:0] rxExp(input logic [3:0] s);
    logic [15:0] all;
    all = 16'h4000 - 16'(s) * 16'h0400;
    return {all / 16'h0010, all - all / 16'h0010};
  endfunction
  function automatic logic [6:0] stExp(input logic s);
    return s ? {3'b000, mgmtMdc, mgmtMdioOut, mgmtMdioOe_n, extMdioIn}
             : {mgmtMdc, mgmtMdioOut, mgmtMdioOe_n, 3'b001, intMdioIn};
  endfunction
  task automatic summarize();
    $display("TB: checks %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(32'haa0f));
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    extMdioIn <= 1'b0;
    wr(`IRQ_MASK_OFF, 32'h1f);
    rd(`IRQ_MASK_OFF);
    chk(q, 32'h0);
    rd(`HWCFG_OFF);
    chk(q, 32'h00050008);
    rd(12'h0f0);
    chk(q, 32'h0);
    $display("TB: reset test done");
    for (int s = 2; s <= 14; s++)
    begin
      sz = 4'(s);
      sel = 1'($urandom);
      en = 1'($urandom);
      wr(`HWCFG_OFF, {11'h0, 1'b1, sz, 11'h0, sel, 1'b0, en, 2'b00});
      {mgmtMdc, mgmtMdioOut, mgmtMdioOe_n, intMdioIn, extMdioIn} <= 5'($urandom);
      rd(`HWCFG_OFF);
      chk(q, {11'h0, 1'b1, sz, 11'h0, sel, 1'b1, en, 2'b00});
      chk(32'(extMiiEnable), 32'(en));
      chk(32'({intMdc, intMdioOut, intMdioOe_n, extMdc, extMdioOut, extMdioOe_n, mgmtMdioIn}), 32'(stExp(sel)));
      rd(`TX_REGION_OFF);
      chk(q, txExp(sz));
      rd(`RX_REGION_OFF);
      chk(q, rxExp(sz));
    end
    chk(32'(nFlush), 32'hd);
    $display("TB: partition test done");
    wr(`HWCFG_OFF, 32'h00150000);
    wr(`IRQ_MASK_OFF, 32'h10);
    @(posedge clock);
    rxDataUsed <= 16'd10543;
    gap(4);
    chk(32'({rxDataFull, irq}), 32'h0);
    @(posedge clock);
    rxDataUsed <= 16'd10544;
    gap(4);
    chk(32'({rxDataFull, irq}), 32'h3);
    @(posedge clock);
    rxDataUsed <= 16'h0;
    wr(`IRQ_STAT_OFF, 32'h10);
    gap(2);
    chk(32'(irq), 32'h0);
    $display("TB: full test done");
    wr(`HWCFG_OFF, 32'h0013001c);
    wr(`IRQ_MASK_OFF, 32'h1f);
    @(posedge clock);
    {txErrorEvt, rxErrorEvt} <= 2'b11;
    @(posedge clock);
    {txErrorEvt, rxErrorEvt} <= 2'b00;
    rd(`IRQ_STAT_OFF);
    chk(q, 32'h03);
    chk(32'(irq), 32'h1);
    wr(`HWCFG_OFF, 32'h0013001d);
    pollReset();
    chk(q, 32'h0005001c);
    rd(`IRQ_STAT_OFF);
    chk(q, 32'h08);
    rd(`IRQ_MASK_OFF);
    chk(q, 32'h0);
    $display("TB: soft reset test done");
    @(posedge clock);
    phyClkRunning <= 1'b0;
    wr(`HWCFG_OFF, 32'h0015001d);
    pollReset();
    chk(q, 32'h0015001e);
    wr(`IRQ_MASK_OFF, 32'h04);
    gap(2);
    chk(32'(irq), 32'h1);
    wr(`IRQ_STAT_OFF, 32'h0c);
    gap(2);
    chk(32'(irq), 32'h0);
    @(posedge clock);
    phyClkRunning <= 1'b1;
    wr(`HWCFG_OFF, 32'h0015001d);
    pollReset();
    chk(q, 32'h0005001c);
    $display("TB: timeout test done");
    @(posedge clock);
    powerSaveExit <= 1'b1;
    @(posedge clock);
    powerSaveExit <= 1'b0;
    wr(`IRQ_MASK_OFF, 32'h1f);
    rd(`IRQ_MASK_OFF);
    chk(q, 32'h0);
    wr(`IRQ_MASK_OFF, 32'h1f);
    rd(`IRQ_MASK_OFF);
    chk(q, 32'h1f);
    $display("TB: write gate test done");
    @(posedge clock);
    nrst <= 1'b0;
    extMdioIn <= 1'b0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    rd(`HWCFG_OFF);
    chk(q, 32'h00050000);
    rd(`TX_REGION_OFF);
    chk(q, txExp(4'h5));
    $display("TB: mid-run reset test done");
    summarize();
  end
  initial
  begin
    repeat (40000) @(posedge clock);
    nMismatch++;
    summarize();
  end
endmodule // tb_top

// ==== hw/fifo_partition.sv ====
// Purpose: splits the shared buffer into transmit and receive regions
// Assumes: reserved size codes are clamped into the legal range
// Notes:   purely combinational
`timescale 1ns/1ps
`include "hwcfg_params.svh"
module fifo_partition
(
  part_if.calc p
);
  logic [3:0]  kb;
  logic [15:0] txTotal;
  logic [15:0] rxTotal;
  logic [15:0] rxStat;

  always_comb
  begin
    kb = p.txAllocKb;
    if (kb < `HWCFG_TXSZ_MIN)
      kb = `HWCFG_TXSZ_MIN;
    else if (kb > `HWCFG_TXSZ_MAX)
      kb = `HWCFG_TXSZ_MAX;
    txTotal         = 16'(kb) << `KB_SHIFT;
    p.txDataBytes   = txTotal - `TX_STATUS_BYTES;
    rxTotal         = `BUF_TOTAL_BYTES - txTotal;
    rxStat          = rxTotal >> `RX_STATUS_SHIFT;
    p.rxStatusBytes = rxStat;
    p.rxDataBytes   = rxTotal - rxStat;
    p.rxDataFull    = ({1'b0, p.rxDataUsed} + {1'b0, `RX_FULL_MARGIN})
                      >= {1'b0, p.rxDataBytes};
  end
endmodule // fifo_partition

// ==== hw/hw_config_fifo_partition.sv ====
// Purpose: hardware configuration register, management port steering,
//          soft reset control and buffer partition over AHB-Lite
// Assumes: single word transfers, all inputs synchronous to clock
// Notes:   every transfer takes one wait state
//
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "hwcfg_params.svh"

// Summary of operation
// - unselected external side pins held low/released, unselected internal side pins driven low
// - detect bit latched from external mdio
// - enable bit switches external mii port
// - stopped phy clocks make soft reset time out
// - soft reset clears mac, control, errors
// - soft reset bit clears itself when done
// - writes ignored until first read after reset
// - transmit data equals allocation minus 512 bytes
// - receive gets remainder, one sixteenth for status
// - receive data full four words early
// - transmit size bits 16-19, reset 5
module hw_config_fifo_partition
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        mgmtMdc,
  input  wire logic        mgmtMdioOut,
  input  wire logic        mgmtMdioOe_n,
  output logic             mgmtMdioIn,
  output logic             intMdc,
  output logic             intMdioOut,
  output logic             intMdioOe_n,
  input  wire logic        intMdioIn,
  output logic             extMdc,
  output logic             extMdioOut,
  output logic             extMdioOe_n,
  input  wire logic        extMdioIn,
  output logic             extMiiEnable,
  input  wire logic        phyClkRunning,
  input  wire logic        powerSaveExit,
  input  wire logic        txErrorEvt,
  input  wire logic        rxErrorEvt,
  input  wire logic [15:0] rxDataUsed,
  output logic             rxDataFull,
  output logic [15:0]      txDataBytes,
  output logic [15:0]      rxDataBytes,
  output logic [15:0]      rxStatusBytes,
  output logic             regionFlush,
  output logic             macCsrReset,
  output logic             errorClear,
  output logic             irq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic              pend_q,     pend_d;
  logic              wr_q,       wr_d;
  logic [11:0]       addr_q,     addr_d;
  logic              ready_q,    ready_d;
  logic [31:0]       rdata_q,    rdata_d;
  logic              wrOpen_q,   wrOpen_d;
  logic              sel_q,      sel_d;
  logic              extEn_q,    extEn_d;
  logic              det_q,      det_d;
  logic              strapDone_q, strapDone_d;
  logic              srTo_q,     srTo_d;
  logic [3:0]        txSz_q,     txSz_d;
  logic              mustOne_q,  mustOne_d;
  logic [`IRQ_W-1:0] stat_q,     stat_d;
  logic [`IRQ_W-1:0] mask_q,     mask_d;
  logic              full_q,     full_d;
  logic              flush_q,    flush_d;
  logic              resetOut_q;
  logic              irq_q;
  logic [15:0]       txData_q, rxData_q, rxStat_q;
  logic              mdcI_q, mdioI_q, oeI_q, mdcE_q, mdioE_q, oeE_q, mIn_q;

  logic              wrNow;
  logic              rdNow;
  logic              srStart;
  logic              srBusy;
  logic              srActive;
  logic              srDone;
  logic              srTimeout;
  logic [`IRQ_W-1:0] statSet;
  logic [31:0]       hwcfgView;

  part_if pif ();

  function automatic logic isReg(input logic [11:0] a, input logic [11:0] off);
    isReg = (a == off);
  endfunction

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  fifo_partition u_part
  (
    .p (pif.calc)
  );

  soft_reset_seq u_soft_reset_request
  (
    .clock         (clock),
    .nrst          (nrst),
    .start         (srStart),
    .phyClkRunning (phyClkRunning),
    .busy          (srBusy),
    .resetActive   (srActive),
    .done          (srDone),
    .timeout       (srTimeout)
  );

  assign pif.txAllocKb  = txSz_q;
  assign pif.rxDataUsed = rxDataUsed;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  assign wrNow   = pend_q && wr_q && wrOpen_q;
  assign rdNow   = pend_q && !wr_q;
  assign srStart = wrNow && isReg(addr_q, `HWCFG_OFF) && hwdata[`HWCFG_SOFT_RST_BIT] && !srBusy;

  always_comb
  begin
    hwcfgView                       = 32'h0000_0000;
    hwcfgView[`HWCFG_SOFT_RST_BIT]  = srBusy;
    hwcfgView[`HWCFG_RST_TMO_BIT]   = srTo_q;
    hwcfgView[`HWCFG_EXTEN_BIT]     = extEn_q;
    hwcfgView[`HWCFG_DET_BIT]       = det_q;
    hwcfgView[`HWCFG_SEL_BIT]       = sel_q;
    hwcfgView[`HWCFG_TXSZ_MSB:`HWCFG_TXSZ_LSB] = txSz_q;
    hwcfgView[`HWCFG_ONE_BIT]       = mustOne_q;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    pend_d      = 1'b0;
    wr_d        = wr_q;
    addr_d      = addr_q;
    ready_d     = 1'b1;
    rdata_d     = rdata_q;
    wrOpen_d    = wrOpen_q;
    sel_d       = sel_q;
    extEn_d     = extEn_q;
    det_d       = det_q;
    strapDone_d = 1'b1;
    srTo_d      = srTo_q;
    txSz_d      = txSz_q;
    mustOne_d   = mustOne_q;
    mask_d      = mask_q;
    statSet     = '0;

    if (hsel && hready && htrans[1] && !pend_q)
    begin
      pend_d  = 1'b1;
      ready_d = 1'b0;
      wr_d    = hwrite;
      addr_d  = haddr[11:0];
    end

    if (!strapDone_q)
      det_d = extMdioIn;

    if (rdNow)
    begin
      wrOpen_d = 1'b1;
      if (isReg(addr_q, `HWCFG_OFF))
        rdata_d = hwcfgView;
      else if (isReg(addr_q, `IRQ_STAT_OFF))
        rdata_d = 32'(stat_q);
      else if (isReg(addr_q, `IRQ_MASK_OFF))
        rdata_d = 32'(mask_q);
      else if (isReg(addr_q, `TX_REGION_OFF))
        rdata_d = {16'h0000, txData_q};
      else if (isReg(addr_q, `RX_REGION_OFF))
        rdata_d = {rxStat_q, rxData_q};
      else
        rdata_d = 32'h0000_0000;
    end
    if (powerSaveExit)
      wrOpen_d = 1'b0;

    if (wrNow && isReg(addr_q, `HWCFG_OFF))
    begin
      sel_d   = hwdata[`HWCFG_SEL_BIT];
      extEn_d = hwdata[`HWCFG_EXTEN_BIT];
      txSz_d  = hwdata[`HWCFG_TXSZ_MSB:`HWCFG_TXSZ_LSB];
      mustOne_d = hwdata[`HWCFG_ONE_BIT];
    end
    if (wrNow && isReg(addr_q, `IRQ_MASK_OFF))
      mask_d = hwdata[`IRQ_W-1:0];

    if (srStart)
      srTo_d = 1'b0;
    if (srTimeout)
      srTo_d = 1'b1;

    if (srActive)
    begin
      txSz_d = `HWCFG_TXSZ_RST;
      mustOne_d = 1'b0;
      mask_d = '0;
    end

    full_d  = pif.rxDataFull;
    flush_d = (txSz_d != txSz_q) || (srActive && !resetOut_q);

    statSet[`IRQ_TXERR_BIT]     = txErrorEvt;
    statSet[`IRQ_RXERR_BIT]     = rxErrorEvt;
    statSet[`IRQ_RST_TMO_BIT]   = srTimeout;
    statSet[`IRQ_RST_DONE_BIT]  = srDone;
    statSet[`IRQ_RXFULL_BIT]    = pif.rxDataFull && !full_q;

    stat_d = stat_q;
    if (wrNow && isReg(addr_q, `IRQ_STAT_OFF))
      stat_d = stat_d & ~hwdata[`IRQ_W-1:0];
    if (srActive)
    begin
      stat_d[`IRQ_TXERR_BIT] = 1'b0;
      stat_d[`IRQ_RXERR_BIT] = 1'b0;
    end
    stat_d = stat_d | statSet;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pend_q      <= 1'b0;
      wr_q        <= 1'b0;
      addr_q      <= 12'h000;
      ready_q     <= 1'b1;
      rdata_q     <= 32'h0000_0000;
      wrOpen_q    <= 1'b0;
      sel_q       <= 1'b0;
      extEn_q     <= 1'b0;
      det_q       <= 1'b0;
      strapDone_q <= 1'b0;
      srTo_q      <= 1'b0;
      txSz_q      <= `HWCFG_TXSZ_RST;
      mustOne_q   <= 1'b0;
      stat_q      <= '0;
      mask_q      <= '0;
      full_q      <= 1'b0;
      flush_q     <= 1'b0;
      resetOut_q  <= 1'b0;
      irq_q       <= 1'b0;
    end
    else
    begin
      pend_q      <= pend_d;
      wr_q        <= wr_d;
      addr_q      <= addr_d;
      ready_q     <= ready_d;
      rdata_q     <= rdata_d;
      wrOpen_q    <= wrOpen_d;
      sel_q       <= sel_d;
      extEn_q     <= extEn_d;
      det_q       <= det_d;
      strapDone_q <= strapDone_d;
      srTo_q      <= srTo_d;
      txSz_q      <= txSz_d;
      mustOne_q   <= mustOne_d;
      stat_q      <= stat_d;
      mask_q      <= mask_d;
      full_q      <= full_d;
      flush_q     <= flush_d;
      resetOut_q  <= srActive;
      irq_q       <= |(stat_q & mask_q);
    end
  end

  // ---------------------------------------------------------------
  // management port steering and region outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      mdcI_q   <= 1'b0;
      mdioI_q  <= 1'b0;
      oeI_q    <= 1'b1;
      mdcE_q   <= 1'b0;
      mdioE_q  <= 1'b0;
      oeE_q    <= 1'b1;
      mIn_q    <= 1'b0;
      txData_q <= 16'h0000;
      rxData_q <= 16'h0000;
      rxStat_q <= 16'h0000;
    end
    else
    begin
      mdcI_q   <= sel_q ? 1'b0 : mgmtMdc;
      mdioI_q  <= sel_q ? 1'b0 : mgmtMdioOut;
      oeI_q    <= sel_q ? 1'b0 : mgmtMdioOe_n;
      mdcE_q   <= sel_q ? mgmtMdc : 1'b0;
      mdioE_q  <= sel_q ? mgmtMdioOut : 1'b0;
      oeE_q    <= sel_q ? mgmtMdioOe_n : 1'b1;
      mIn_q    <= sel_q ? extMdioIn : intMdioIn;
      txData_q <= pif.txDataBytes;
      rxData_q <= pif.rxDataBytes;
      rxStat_q <= pif.rxStatusBytes;
    end
  end

  assign hreadyout     = ready_q;
  assign hresp         = 1'b0;
  assign hrdata        = rdata_q;
  assign mgmtMdioIn    = mIn_q;
  assign intMdc        = mdcI_q;
  assign intMdioOut    = mdioI_q;
  assign intMdioOe_n   = oeI_q;
  assign extMdc        = mdcE_q;
  assign extMdioOut    = mdioE_q;
  assign extMdioOe_n   = oeE_q;
  assign extMiiEnable  = extEn_q;
  assign rxDataFull    = full_q;
  assign txDataBytes   = txData_q;
  assign rxDataBytes   = rxData_q;
  assign rxStatusBytes = rxStat_q;
  assign regionFlush   = flush_q;
  assign macCsrReset   = resetOut_q;
  assign errorClear    = resetOut_q;
  assign irq           = irq_q;
endmodule // hw_config_fifo_partition

// ==== hw/hwcfg_params.svh ====
// Purpose: constants for the hardware configuration and buffer partition block
// Assumes: 200 MHz clock, AHB-Lite word registers
// Notes:   offsets are byte addresses
`ifndef HWCFG_PARAMS_SVH
`define HWCFG_PARAMS_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define HWCFG_OFF          12'h074
`define IRQ_STAT_OFF       12'h100
`define IRQ_MASK_OFF       12'h104
`define TX_REGION_OFF      12'h108
`define RX_REGION_OFF      12'h10c

// ---------------------------------------------------------------
// hardware_configuration fields
// ---------------------------------------------------------------
`define HWCFG_SOFT_RST_BIT 0
`define HWCFG_RST_TMO_BIT  1
`define HWCFG_EXTEN_BIT    2
`define HWCFG_DET_BIT      3
`define HWCFG_SEL_BIT      4
`define HWCFG_TXSZ_LSB     16
`define HWCFG_TXSZ_MSB     19
`define HWCFG_ONE_BIT      20
`define HWCFG_TXSZ_RST     4'h5
`define HWCFG_TXSZ_MIN     4'h2
`define HWCFG_TXSZ_MAX     4'he

// ---------------------------------------------------------------
// interrupt status and mask bits
// ---------------------------------------------------------------
`define IRQ_TXERR_BIT      0
`define IRQ_RXERR_BIT      1
`define IRQ_RST_TMO_BIT    2
`define IRQ_RST_DONE_BIT   3
`define IRQ_RXFULL_BIT     4
`define IRQ_W              5

// ---------------------------------------------------------------
// buffer partition
// ---------------------------------------------------------------
`define BUF_TOTAL_BYTES    16'h4000
`define TX_STATUS_BYTES    16'h0200
`define RX_FULL_MARGIN     16'h0010
`define KB_SHIFT           10
`define RX_STATUS_SHIFT    4

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS      5
`define RSTSEQ_TIMEOUT_NS  10000
`define RSTSEQ_TIMEOUT_CYC (`RSTSEQ_TIMEOUT_NS / `CLK_PERIOD_NS)
`define RSTSEQ_PULSE_NS    40
`define RSTSEQ_PULSE_CYC   ((`RSTSEQ_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== hw/hwcfg_pkg.sv ====
// Purpose: types for the hardware configuration block
// Assumes: nothing
// Notes:   one-hot soft reset sequencer states
package hwcfg_pkg;
  typedef enum logic [2:0]
  {
    SR_IDLE  = 3'b001,
    SR_WAIT  = 3'b010,
    SR_PULSE = 3'b100
  } srState_t;
endpackage

// ==== hw/part_if.sv ====
// Purpose: buffer partition signals between configuration and calculator
// Assumes: sizes in bytes, except txAllocKb in kilobytes
// Notes:   none
`timescale 1ns/1ps
interface part_if;
  logic [3:0]  txAllocKb;
  logic [15:0] rxDataUsed;
  logic [15:0] txDataBytes;
  logic [15:0] rxDataBytes;
  logic [15:0] rxStatusBytes;
  logic        rxDataFull;
  modport cfg  (output txAllocKb, rxDataUsed, input txDataBytes, rxDataBytes, rxStatusBytes, rxDataFull);
  modport calc (input txAllocKb, rxDataUsed, output txDataBytes, rxDataBytes, rxStatusBytes, rxDataFull);
endinterface // part_if

// ==== hw/soft_reset_seq.sv ====
// Purpose: soft reset sequencer with timeout on stopped phy clocks
// Assumes: phyClkRunning is synchronous to clock
// Notes:   start is ignored while busy
`timescale 1ns/1ps
`include "hwcfg_params.svh"
module soft_reset_seq
(
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic start,
  input  wire logic phyClkRunning,
  output logic      busy,
  output logic      resetActive,
  output logic      done,
  output logic      timeout
);
  hwcfg_pkg::srState_t state_q;
  hwcfg_pkg::srState_t state_d;
  logic [15:0]         count_q;
  logic [15:0]         count_d;

  always_comb
  begin
    state_d = state_q;
    count_d = count_q;
    done    = 1'b0;
    timeout = 1'b0;
    case (state_q)
      hwcfg_pkg::SR_IDLE:
      begin
        count_d = 16'h0000;
        if (start)
          state_d = hwcfg_pkg::SR_WAIT;
      end
      hwcfg_pkg::SR_WAIT:
      begin
        if (phyClkRunning)
        begin
          state_d = hwcfg_pkg::SR_PULSE;
          count_d = 16'h0000;
        end
        else if (count_q == 16'(`RSTSEQ_TIMEOUT_CYC - 1))
        begin
          timeout = 1'b1;
          state_d = hwcfg_pkg::SR_IDLE;
        end
        else
          count_d = count_q + 16'h0001;
      end
      hwcfg_pkg::SR_PULSE:
      begin
        if (count_q == 16'(`RSTSEQ_PULSE_CYC - 1))
        begin
          done    = 1'b1;
          state_d = hwcfg_pkg::SR_IDLE;
        end
        else
          count_d = count_q + 16'h0001;
      end
      default:
        state_d = hwcfg_pkg::SR_IDLE;
    endcase
  end

  assign busy        = (state_q != hwcfg_pkg::SR_IDLE);
  assign resetActive = (state_q == hwcfg_pkg::SR_PULSE);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= hwcfg_pkg::SR_IDLE;
      count_q <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end
endmodule // soft_reset_seq
